//--- rtl/poll_pkg.sv
// constants shared by the poll protocol engine and its header store
// assumes a byte-wide serial transmitter and receiver outside the block
package poll_pkg;
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_NAK = 8'h15;
  localparam logic [7:0] CMD_SEND = 8'h40;
  localparam logic [7:0] CMD_RECEIVE = 8'h44;
  localparam logic [11:0] WORD_NUMBER_MAX = 12'h800;
  localparam int CLK_HZ = 10_000_000;
  localparam int WINDOW_MS = 500;
  localparam int PACE_MS = 1;
  localparam int WINDOW_CYCLES = CLK_HZ / 1000 * WINDOW_MS;
  localparam int PACE_CYCLES = CLK_HZ / 1000 * PACE_MS;
  localparam int HDR_DEPTH = 8;
  typedef enum logic [1:0] {
    RES_NONE,
    RES_DONE,
    RES_RETRY
  } result_t;
endpackage

//--- rtl/hdr_store.sv
// small memory holding the outgoing header bytes of one request
// assumes the engine writes a full header before it reads it back
module hdr_store
  import poll_pkg::*;
#(
  parameter int DEPTH = HDR_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // write side
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read side
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [DEPTH];
  logic [7:0] next_rd_data;

  always_comb begin
    next_rd_data = mem[rd_addr];
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= next_rd_data;
    end
  end
endmodule

//--- rtl/poll_engine.sv
// receive-request framer and retry engine of the operator panel side
// assumes a byte transmitter with tx_ready and a receiver giving rx_valid pulses
//
// Summary of operation
// - after start, wait one window for acknowledge
// - no first acknowledge: send start again
// - matching reply checksum ends transfer as done
// - timeout or wrong character restarts transfer
// - receive requests use same retry behaviour
// - variant one header: command, hex number, cr, etx, sum
// - variant one sum covers command through etx
// - variant two header: command, address, count, etx, sum
// - data phase bytes paced one per millisecond
// - no hardware flow control lines used
// - response window is 500 ms timeout
// - variant one values are four hex characters
// - variant two words go high byte first
module poll_engine
  import poll_pkg::*;
#(
  parameter int WINDOW_CNT = WINDOW_CYCLES,
  parameter int PACE_CNT = PACE_CYCLES,
  parameter int MAX_BYTES = 255
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // request from the application
  input wire logic req_valid,
  output logic req_ready,
  input wire logic binary_block_variant,
  input wire logic [11:0] word_number,
  input wire logic [15:0] start_addr,
  input wire logic [7:0] byte_count,
  // serial transmitter
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // serial receiver
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // received data and result
  output logic data_valid,
  output logic [7:0] data_byte,
  output logic done,
  output logic fail,
  output logic [15:0] word_value
);
  localparam int TW = $clog2(WINDOW_CNT + 1);
  localparam int AW = $clog2(HDR_DEPTH);

  if (WINDOW_CNT < 2 || PACE_CNT < 1 || PACE_CNT >= WINDOW_CNT || MAX_BYTES > 255) begin
    $error("poll_engine: unsupported parameter values");
  end
  typedef enum {
    S_IDLE, S_BUILD, S_STX, S_ACK, S_HDR, S_HDR_WAIT, S_REPLY_STX, S_BODY, S_SUM
  } state_t;

  // ----------------------------------------
  // state
  // ----------------------------------------
  state_t state, next_state;
  logic [TW-1:0] timer, next_timer;
  logic [TW-1:0] pace, next_pace;
  logic [AW-1:0] idx, next_idx;
  logic [AW-1:0] hdr_len, next_hdr_len;
  logic [7:0] sum, next_sum;
  logic [7:0] cnt, next_cnt;
  logic bin, next_bin;
  logic [15:0] wv, next_wv;
  logic [15:0] addr, next_addr;
  logic [11:0] wnum, next_wnum;
  logic [7:0] bcnt, next_bcnt;
  logic [15:0] next_word_value;
  logic [7:0] mem_q;
  logic wr_en;
  logic [7:0] wr_byte;
  logic [7:0] next_data_byte;
  logic next_data_valid, next_done, next_fail;

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction
  function automatic logic [3:0] hex_val(input logic [7:0] c);
    hex_val = (c >= 8'h41) ? 4'(c - 8'h37) : 4'(c - 8'h30);
  endfunction
  hdr_store #(.DEPTH(HDR_DEPTH)) u_hdr (
    .clk(clk), .nrst(nrst),
    .wr_en(wr_en), .wr_addr(idx), .wr_data(wr_byte),
    .rd_addr(next_idx), .rd_data(mem_q)
  );
  // header byte at position idx, written during the build phase
  always_comb begin
    wr_byte = CMD_RECEIVE;
    if (bin) begin
      case (idx)
        3'd0: wr_byte = CMD_RECEIVE;
        3'd1: wr_byte = addr[15:8];
        3'd2: wr_byte = addr[7:0];
        3'd3: wr_byte = bcnt;
        default: wr_byte = CH_ETX;
      endcase
    end else begin
      case (idx)
        3'd0: wr_byte = CMD_RECEIVE;
        3'd1: wr_byte = hex_char(4'h0);
        3'd2: wr_byte = hex_char(wnum[11:8]);
        3'd3: wr_byte = hex_char(wnum[7:4]);
        3'd4: wr_byte = hex_char(wnum[3:0]);
        3'd5: wr_byte = CH_CR;
        default: wr_byte = CH_ETX;
      endcase
    end
  end

  assign wr_en = (state == S_BUILD);
  assign req_ready = (state == S_IDLE);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_timer = timer;
    next_pace = (pace != '0) ? pace - 1'b1 : pace;
    next_idx = idx;
    next_hdr_len = hdr_len;
    next_sum = sum;
    next_cnt = cnt;
    next_bin = bin;
    next_wv = wv;
    next_addr = addr;
    next_wnum = wnum;
    next_bcnt = bcnt;
    next_word_value = word_value;
    next_data_valid = 1'b0;
    next_data_byte = data_byte;
    next_done = 1'b0;
    next_fail = 1'b0;
    tx_valid = 1'b0;
    tx_data = CH_STX;
    case (state)
      S_IDLE: begin
        if (req_valid) begin
          next_bin = binary_block_variant;
          next_addr = start_addr;
          next_wnum = (word_number > WORD_NUMBER_MAX) ? WORD_NUMBER_MAX : word_number;
          next_bcnt = byte_count;
          next_hdr_len = binary_block_variant ? 3'd4 : 3'd6;
          next_idx = '0;
          next_state = S_BUILD;
        end
      end
      S_BUILD: begin
        next_idx = idx + 1'b1;
        if (idx == hdr_len) begin
          next_idx = '0;
          next_state = S_STX;
        end
      end
      S_STX: begin
        tx_valid = 1'b1;
        tx_data = CH_STX;
        if (tx_ready) begin
          next_timer = TW'(WINDOW_CNT);
          next_state = S_ACK;
        end
      end
      S_ACK: begin
        next_timer = timer - 1'b1;
        if (rx_valid && rx_data == CH_ACK) begin
          next_idx = '0;
          next_sum = 8'h00;
          next_pace = '0;
          next_state = S_HDR;
        end else if (rx_valid || timer == '0) begin
          next_fail = 1'b1;
          next_state = S_STX;
        end
      end
      S_HDR: begin
        // paced one byte per pace period
        if (pace == '0) begin
          tx_valid = 1'b1;
          tx_data = (idx > hdr_len) ? sum : mem_q;
          if (tx_ready) begin
            next_pace = TW'(PACE_CNT);
            if (idx > hdr_len) begin
              next_timer = TW'(WINDOW_CNT);
              next_state = S_REPLY_STX;
            end else begin
              next_sum = sum + mem_q;
              next_idx = idx + 1'b1;
              next_state = S_HDR_WAIT;
            end
          end
        end
      end
      S_HDR_WAIT: begin
        next_state = S_HDR;
      end
      S_REPLY_STX, S_BODY, S_SUM: begin
        next_timer = timer - 1'b1;
        if (timer == '0) begin
          next_fail = 1'b1;
          next_state = S_STX;
        end else if (rx_valid) begin
          next_timer = TW'(WINDOW_CNT);
          if (state == S_REPLY_STX) begin
            next_sum = 8'h00;
            next_cnt = 8'h00;
            next_wv = 16'h0000;
            if (rx_data == CH_STX) begin
              next_state = S_BODY;
            end else begin // nak or anything else
              next_fail = 1'b1;
              next_state = S_STX;
            end
          end else if (state == S_BODY) begin
            next_sum = sum + rx_data;
            if (rx_data == CH_ETX && (!bin || cnt == bcnt)) begin
              next_state = S_SUM;
            end else if (bin) begin
              next_cnt = cnt + 1'b1;
              next_data_byte = rx_data;
              next_data_valid = 1'b1;
              if (cnt == bcnt) begin
                next_fail = 1'b1;
                next_state = S_STX;
              end
            end else if (rx_data != CH_CR) begin
              next_wv = {wv[11:0], hex_val(rx_data)};
            end
          end else begin
            // matching checksum completes the request
            if (rx_data == sum) begin
              next_done = 1'b1;
              next_word_value = bin ? word_value : wv;
              next_state = S_IDLE;
            end else begin
              next_fail = 1'b1;
              next_state = S_STX;
            end
          end
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= S_IDLE;
      timer <= '0;
      pace <= '0;
      idx <= '0;
      hdr_len <= '0;
      sum <= 8'h00;
      cnt <= 8'h00;
      bin <= 1'b0;
      wv <= 16'h0000;
      addr <= 16'h0000;
      wnum <= 12'h000;
      bcnt <= 8'h00;
      data_valid <= 1'b0;
      data_byte <= 8'h00;
      done <= 1'b0;
      fail <= 1'b0;
      word_value <= 16'h0000;
    end else begin
      state <= next_state;
      timer <= next_timer;
      pace <= next_pace;
      idx <= next_idx;
      hdr_len <= next_hdr_len;
      sum <= next_sum;
      cnt <= next_cnt;
      bin <= next_bin;
      wv <= next_wv;
      addr <= next_addr;
      wnum <= next_wnum;
      bcnt <= next_bcnt;
      data_valid <= next_data_valid;
      data_byte <= next_data_byte;
      done <= next_done;
      fail <= next_fail;
      word_value <= next_word_value;
    end
  end
endmodule

//--- tb/poll_engine_chk_sva.sv
// port assertions for the poll engine
// assumes one clock domain and the bind at the foot of this file
module poll_engine_chk
  import poll_pkg::*;
#(
  parameter int WINDOW_CNT = 200,
  parameter int PACE_CNT = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // request and link
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // results
  input wire logic data_valid,
  input wire logic done,
  input wire logic fail
);
  timeunit 1ns;
  timeprecision 1ns;
  // only the first byte after a request or a failed attempt opens a transfer;
  // header bytes and sums may carry the start value too
  logic await_ack, next_await_ack, opening, next_opening;
  logic [15:0] quiet, next_quiet, since_tx, next_since_tx;
  wire tx_take = tx_valid && tx_ready;
  always_comb begin
    next_opening = ((req_valid && req_ready) || fail) ? 1'b1 : (tx_take ? 1'b0 : opening);
    next_await_ack = (tx_take && (opening || fail)) ? 1'b1 : (rx_valid ? 1'b0 : await_ack);
    next_quiet = (req_ready || tx_take || rx_valid) ? 16'h0 : quiet + 16'h1;
    next_since_tx = tx_take ? 16'h0 : since_tx + {15'h0, since_tx != 16'hffff};
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      await_ack <= 1'b0;
      opening <= 1'b0;
      quiet <= 16'h0;
      since_tx <= 16'hffff;
    end else begin
      await_ack <= next_await_ack;
      opening <= next_opening;
      quiet <= next_quiet;
      since_tx <= next_since_tx;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  chk_stx_first: assert property (
    req_valid && req_ready |-> ##[1:12] (tx_valid && tx_data == CH_STX)) else $error("no start");
  chk_hold_stx: assert property (
    await_ack && tx_valid |-> tx_data == CH_STX) else $error("byte sent before ack");
  chk_ack_cmd: assert property (
    rx_valid && rx_data == CH_ACK && await_ack |-> ##[1:12] (tx_valid && tx_data == CMD_RECEIVE))
    else $error("no command after ack");
  chk_wrong_char: assert property (
    rx_valid && rx_data != CH_ACK && await_ack |=> fail) else $error("wrong char not refused");
  chk_fail_restart: assert property (
    fail |-> ##[1:12] (tx_valid && tx_data == CH_STX)) else $error("no restart");
  chk_window_cap: assert property (
    quiet <= WINDOW_CNT + 16) else $error("window overrun");
  chk_timeout_late: assert property (
    fail && !$past(rx_valid) |-> $past(quiet) >= WINDOW_CNT - 2) else $error("early timeout");
  chk_pace_gap: assert property (
    $rose(tx_valid) |-> since_tx >= PACE_CNT - 1) else $error("pace too fast");
  chk_done_close: assert property (
    done |-> $past(rx_valid) && !fail) else $error("done without closing byte");
  cov_done: cover property (done);
  cov_fail: cover property (fail);
  cov_data: cover property (data_valid);
endmodule
bind poll_engine poll_engine_chk #(.WINDOW_CNT(WINDOW_CNT), .PACE_CNT(PACE_CNT)) u_chk (
  .clk(clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
  .rx_data(rx_data), .data_valid(data_valid), .done(done), .fail(fail));

//--- tb/plc_model.sv
// controller model: acks starts, collects headers, answers with data
// assumes tx_data holds while tx_valid waits; fault acts on first try only
module plc_model
  import poll_pkg::*;
#(
  parameter logic [15:0] WV = 16'h0
) (
  input wire logic clk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic binary_block_variant,
  input wire logic [1:0] fault
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] hdr[$];
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  task automatic get(output logic [7:0] v);
    while (tx_valid !== 1'b1) @(posedge clk);
    v = tx_data;
    tx_ready <= 1'b1;
    @(posedge clk);
    tx_ready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic put(input logic [7:0] v);
    rx_data <= v;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~v;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    logic [7:0] b, s;
    logic bad, retry;
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h0;
    retry = 1'b0;
    forever begin
      get(b);
      if (b != CH_STX) continue;
      bad = fault != 2'd0 && !retry;
      retry = bad;
      hdr.delete();
      if (bad && fault == 2'd2) continue;
      put((bad && fault == 2'd1) ? CH_NAK : CH_ACK);
      if (bad && fault == 2'd1) continue;
      repeat (binary_block_variant ? 6 : 8) begin
        get(b);
        hdr.push_back(b);
      end
      s = 8'h0;
      put(CH_STX);
      if (binary_block_variant) begin
        for (int i = 0; i < int'(hdr[3]); i++) begin
          put(8'ha0 + 8'(i));
          s += 8'ha0 + 8'(i);
        end
      end else begin
        for (int i = 3; i >= 0; i--) begin
          put(hx(WV[4*i +: 4]));
          s += hx(WV[4*i +: 4]);
        end
        put(CH_CR);
        s += CH_CR;
      end
      put(CH_ETX);
      s += CH_ETX;
      put(s ^ {7'h0, bad && fault == 2'd3});
    end
  end
endmodule

//--- tb/testbench.sv
// self-checking bench for the poll engine with the controller model
// assumes shortened window and pace counts
module testbench;
  import poll_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] WV = 16'hc3fc;
  logic clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, binary_block_variant = 1'b0;
  logic [11:0] word_number = 12'h0;
  logic [15:0] start_addr = 16'h0, word_value;
  logic [7:0] byte_count = 8'h0, tx_data, rx_data, data_byte;
  logic [1:0] fault = 2'd0;
  logic req_ready, tx_valid, tx_ready, rx_valid, data_valid, done, fail;
  int bad_count = 0, n_checks = 0;
  always #50 clk = ~clk;
  poll_engine #(.WINDOW_CNT(200), .PACE_CNT(3)) u_dut (
    .clk(clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
    .binary_block_variant(binary_block_variant), .word_number(word_number),
    .start_addr(start_addr), .byte_count(byte_count), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .data_valid(data_valid), .data_byte(data_byte), .done(done), .fail(fail),
    .word_value(word_value));
  plc_model #(.WV(WV)) u_plc (
    .clk(clk), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data),
    .binary_block_variant(binary_block_variant), .fault(fault));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run(input string nm, input logic v, input logic [11:0] w,
      input logic [15:0] a, input logic [7:0] c, input logic [1:0] f, input logic [7:0] e[$]);
    int fails, k;
    logic [7:0] s, got[$];
    @(posedge clk);
    check("ready", 16'h1, {15'h0, req_ready});
    binary_block_variant <= v;
    word_number <= w;
    start_addr <= a;
    byte_count <= c;
    fault <= f;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    fails = 0;
    k = 0;
    while (done !== 1'b1 && k < 5000) begin
      @(negedge clk);
      k++;
      if (k == 1) check("busy", 16'h0, {15'h0, req_ready});
      if (data_valid === 1'b1) got.push_back(data_byte);
      // a failed attempt discards whatever it delivered
      if (fail === 1'b1) begin
        fails++;
        got.delete();
      end
    end
    check("done", 16'h1, {15'h0, done});
    check("fails", 16'(f != 2'd0), 16'(fails));
    s = 8'h0;
    foreach (e[i]) s += e[i];
    e.push_back(s);
    foreach (e[i]) check("header", e[i], u_plc.hdr[i]);
    if (v) begin
      check("count", 16'(c), 16'(got.size()));
      foreach (got[i]) check("data", 8'ha0 + 8'(i), got[i]);
    end else begin
      check("value", WV, word_value);
    end
    $display("test %s finished", nm);
  endtask
  task automatic t_ascii_max();
    run("ascii_max", 1'b0, 12'h800, 16'h0, 8'h0, 2'd0, '{8'h44, 8'h30, 8'h38, 8'h30,
      8'h30, 8'h0d, 8'h03});
  endtask
  task automatic t_block();
    run("block", 1'b1, 12'h0, 16'h1234, 8'h04, 2'd0, '{8'h44, 8'h12, 8'h34, 8'h04, 8'h03});
  endtask
  task automatic t_nak();
    run("nak", 1'b0, 12'h7a5, 16'h0, 8'h0, 2'd1, '{8'h44, 8'h30, 8'h37, 8'h41, 8'h35,
      8'h0d, 8'h03});
  endtask
  task automatic t_silent();
    run("silent", 1'b1, 12'h0, 16'hffff, 8'h02, 2'd2, '{8'h44, 8'hff, 8'hff, 8'h02, 8'h03});
  endtask
  task automatic t_bad_sum();
    run("bad_sum", 1'b1, 12'h0, 16'h0001, 8'h06, 2'd3, '{8'h44, 8'h00, 8'h01, 8'h06, 8'h03});
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_ascii_max();
    t_block();
    t_nak();
    t_silent();
    t_bad_sum();
    report_and_stop();
  end
endmodule
